// file: hdl/boot_serial_command_responder.sv
// Purpose: Command responder of the single-boot serial loader (product info tail, chip erase)
// Assumes: Receive/transmit bytes, errors and baud check come from logic on ref_clk
// Notes:   Reply bytes 5 to 50 and 55 to 56 are supplied by headByte one clock after headIdx_ff; bytes 51 to 54 carry FLASH_END
//
// Contract
// - Reply bytes 57-65 give 16K group: start 0, size 0x2000 LSB first, count 0.
// - Reply bytes 66-74 give 32K group: start 3F800000, size 0x4000, count 2.
// - Reply bytes 75-83 give 64K group: start 3F810000, size 0x8000, count 1.
// - Reply bytes 84-92 give 128K group: start 3F820000, size 0x10000, count 3.
// - Byte 93 is checksum of bytes 5-92, then wait for a command.
// - Report flash end 3F83FFFF; separate 128-word page feeds the product reply.
// - Echo mode byte; abort silently if UART baud rate cannot be set.
// - Command 40H requests chip erase; device acknowledges with 40H.
// - Bad command gives low nibble 1H, receive error 8H, then await command.
// - Clocked mode never checks receive errors nor sends error acknowledge.
// - Host confirms with 54H; device echoes it or sends negative acknowledge.
// - After erase send 4FH on success, 4CH on failure, then await command.
// - Erase clears all blocks and protection without password, then sets security flag only on success.
// - Negative acknowledge upper nibble repeats previous command's upper nibble.
`default_nettype none
module boot_serial_command_responder
    import boot_resp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire rx_byte_t   rxByte,
    input  wire logic       baudOk,
    input  wire logic       txReady,
    input  wire logic [7:0] headByte,
    input  wire logic       eraseDone,
    input  wire logic       eraseOk,
    output logic            txValid_ff,
    output logic      [7:0] txData_ff,
    output logic      [6:0] headIdx_ff,
    output logic            eraseReq_ff,
    output logic            ioMode_ff,
    output logic            aborted_ff,
    output logic            security_flag_ff
);
    state_t     state_ff;
    state_t     nxtState;
    logic [7:0] lastCmd_ff;
    logic [7:0] sum_ff;
    logic       phase_ff;
    logic [7:0] romData_ff;
    logic       doneSeen_ff;
    logic       doneOk_ff;

    group_table_rom u_rom (
        .ref_clk    (ref_clk),
        .byteIdx    (headIdx_ff),
        .romData_ff (romData_ff)
    );

    // Decoding of the received byte in the current state
    wire        txFree    = !txValid_ff || txReady;
    wire        rxTake    = rxByte.valid && txFree;
    wire        rxErrSeen = rxByte.err && !ioMode_ff;
    wire [7:0]  nakErr    = {lastCmd_ff[7:4], NAK_RXERR};
    wire [7:0]  nakBad    = {lastCmd_ff[7:4], NAK_BADCMD};
    wire        cmdErase  = rxByte.data == CMD_ERASE;
    wire        cmdInfo   = rxByte.data == CMD_INFO;
    wire        modeUart  = rxByte.data == MODE_UART;
    wire        modeIo    = rxByte.data == MODE_IO;
    wire        isEndByte = headIdx_ff >= IDX_END_LO && headIdx_ff <= IDX_END_HI;
    wire [1:0]  endSel    = 2'(headIdx_ff - IDX_END_LO);
    wire [7:0]  endByte   = FLASH_END[8*endSel +: 8];
    wire [7:0]  checkByte = 8'(~sum_ff + 8'h01);
    wire [7:0]  infoByte  = (headIdx_ff == IDX_CHECK) ? checkByte :
                            (headIdx_ff >= IDX_GROUP) ? romData_ff :
                            isEndByte ? endByte : headByte;
    wire        infoSend  = state_ff == ST_INFO && phase_ff && txFree;
    wire        infoLast  = headIdx_ff == IDX_CHECK;
    wire        modeStep  = state_ff == ST_MODE && rxTake && (modeUart || modeIo);
    wire        cmdStep   = state_ff == ST_CMD && rxTake;
    wire        confStep  = state_ff == ST_CONF && rxTake;
    wire        doneNow   = state_ff == ST_ERASE && (eraseDone || doneSeen_ff);
    wire        eraseRes  = eraseDone ? eraseOk : doneOk_ff;                  // Kept if stalled
    wire        eraseEnd  = doneNow && txFree;

    // Next state of the exchange
    always_comb begin
        nxtState = state_ff;
        case (state_ff)
            ST_MODE: begin
                if (modeStep) begin
                    nxtState = (modeUart && !baudOk) ? ST_DEAD : ST_CMD;
                end
            end
            ST_CMD: begin
                if (cmdStep && !rxErrSeen && cmdErase) begin
                    nxtState = ST_CONF;
                end else if (cmdStep && !rxErrSeen && cmdInfo) begin
                    nxtState = ST_INFO;
                end
            end
            ST_CONF: begin
                if (confStep) begin
                    nxtState = (!rxErrSeen && rxByte.data == CODE_CONFIRM) ? ST_ERASE : ST_CMD;
                end
            end
            ST_ERASE: begin
                if (eraseEnd) begin
                    nxtState = ST_CMD;
                end
            end
            ST_INFO: begin
                if (infoSend && infoLast) begin
                    nxtState = ST_CMD;
                end
            end
            ST_DEAD: nxtState = ST_DEAD;
            default: nxtState = ST_MODE;
        endcase
    end

    // Byte to transmit this cycle, if any
    logic       txLoad;
    logic [7:0] txNext;
    always_comb begin
        txLoad = 1'b0;
        txNext = 8'h00;
        if (modeStep && !(modeUart && !baudOk)) begin
            txLoad = 1'b1;
            txNext = rxByte.data;
        end else if (cmdStep) begin
            txLoad = 1'b1;
            txNext = rxErrSeen ? nakErr : (cmdErase || cmdInfo) ? rxByte.data : nakBad;
        end else if (confStep) begin
            txLoad = 1'b1;
            txNext = rxErrSeen ? nakErr :
                     (rxByte.data == CODE_CONFIRM) ? CODE_CONFIRM : nakBad;
        end else if (eraseEnd) begin
            txLoad = 1'b1;
            txNext = eraseRes ? ERASE_OK : ERASE_FAIL;
        end else if (infoSend) begin
            txLoad = 1'b1;
            txNext = infoByte;
        end
    end

    // State and transmit holding register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff   <= ST_MODE;
            txValid_ff <= 1'b0;
            txData_ff  <= 8'h00;
        end else begin
            state_ff <= nxtState;
            if (txLoad) begin
                txValid_ff <= 1'b1;
                txData_ff  <= txNext;
            end else if (txReady) begin
                txValid_ff <= 1'b0;
            end
        end
    end

    // Mode, abort flag and previous command register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ioMode_ff  <= 1'b0;
            aborted_ff <= 1'b0;
            lastCmd_ff <= 8'h00;
        end else begin
            if (modeStep) begin
                ioMode_ff  <= modeIo;
                aborted_ff <= modeUart && !baudOk;
            end
            if (cmdStep && !rxErrSeen) begin
                lastCmd_ff <= rxByte.data;
            end
        end
    end

    // Product reply sequencing and running sum
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            headIdx_ff <= IDX_FIRST;
            phase_ff   <= 1'b0;
            sum_ff     <= 8'h00;
        end else if (state_ff != ST_INFO) begin
            headIdx_ff <= IDX_FIRST;
            phase_ff   <= 1'b0;
            sum_ff     <= 8'h00;
        end else if (!phase_ff) begin
            phase_ff <= 1'b1;
        end else if (infoSend) begin
            phase_ff   <= 1'b0;
            headIdx_ff <= headIdx_ff + 7'h01;
            sum_ff     <= 8'(sum_ff + infoByte);
        end
    end

    // Erase request and security flag
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eraseReq_ff      <= 1'b0;
            security_flag_ff <= 1'b0;
        end else begin
            if (confStep && !rxErrSeen && rxByte.data == CODE_CONFIRM) begin
                eraseReq_ff <= 1'b1;
            end else if (eraseDone) begin
                eraseReq_ff <= 1'b0;
            end
            if (eraseEnd && eraseRes) begin
                security_flag_ff <= 1'b1;
            end
        end
    end

    // Done pulse kept while the previous byte still waits, so the result is never lost
    always_ff @(posedge ref_clk) begin
        if (reset || eraseEnd) begin
            doneSeen_ff <= 1'b0;
            doneOk_ff   <= 1'b0;
        end else if (state_ff == ST_ERASE && eraseDone) begin
            doneSeen_ff <= 1'b1;
            doneOk_ff   <= eraseOk;
        end
    end

    // Checks of the exchange
    property p_mode_echo;
        @(posedge ref_clk) disable iff (reset)
        modeStep && !(modeUart && !baudOk) |=> txValid_ff && txData_ff == $past(rxByte.data);
    endproperty
    a_mode_echo: assert property (p_mode_echo) else $error("mode byte not echoed");

    property p_abort_silent;
        @(posedge ref_clk) disable iff (reset)
        modeStep && modeUart && !baudOk |=> state_ff == ST_DEAD && !txValid_ff;
    endproperty
    a_abort_silent: assert property (p_abort_silent) else $error("abort not silent");

    property p_erase_ack;
        @(posedge ref_clk) disable iff (reset)
        cmdStep && !rxErrSeen && cmdErase |=> txData_ff == CMD_ERASE && state_ff == ST_CONF;
    endproperty
    a_erase_ack: assert property (p_erase_ack) else $error("erase ack wrong");

    property p_bad_cmd;
        @(posedge ref_clk) disable iff (reset)
        cmdStep && !rxErrSeen && !cmdErase && !cmdInfo
        |=> txData_ff == {$past(lastCmd_ff[7:4]), NAK_BADCMD} && state_ff == ST_CMD;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad command nak wrong");

    property p_no_err_ack_io;
        @(posedge ref_clk) disable iff (reset)
        ioMode_ff && (cmdStep || confStep) |-> txNext[3:0] != NAK_RXERR;
    endproperty
    a_no_err_ack_io: assert property (p_no_err_ack_io) else $error("error ack in io mode");

    property p_confirm_echo;
        @(posedge ref_clk) disable iff (reset)
        confStep && !rxErrSeen && rxByte.data == CODE_CONFIRM
        |=> txData_ff == CODE_CONFIRM ##1 eraseReq_ff;
    endproperty
    a_confirm_echo: assert property (p_confirm_echo) else $error("confirm not echoed");

    property p_erase_result;
        @(posedge ref_clk) disable iff (reset)
        eraseEnd |=> txData_ff == ($past(eraseRes) ? ERASE_OK : ERASE_FAIL) && state_ff == ST_CMD;
    endproperty
    a_erase_result: assert property (p_erase_result) else $error("erase result wrong");

    property p_secure_set;
        @(posedge ref_clk) disable iff (reset)
        eraseEnd && eraseRes |=> security_flag_ff;
    endproperty
    a_secure_set: assert property (p_secure_set) else $error("security flag not set");

    property p_checksum;
        @(posedge ref_clk) disable iff (reset)
        infoSend && infoLast |-> 8'(sum_ff + txNext) == 8'h00 ##1 state_ff == ST_CMD;
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum wrong");
endmodule
`default_nettype wire

// file: hdl/boot_resp_pkg.sv
// Purpose: Shared constants and carriers of the serial boot command responder
// Assumes: Byte-level receive and transmit are handled by the serial port logic outside
// Notes:   Group table lists start, size in halfwords and count, transmitted LSB first
`default_nettype none
package boot_resp_pkg;
    // Serial mode bytes and command codes
    localparam logic [7:0] MODE_UART    = 8'h86;
    localparam logic [7:0] MODE_IO      = 8'h30;
    localparam logic [7:0] CMD_INFO     = 8'h30;
    localparam logic [7:0] CMD_ERASE    = 8'h40;
    localparam logic [7:0] CODE_CONFIRM = 8'h54;
    localparam logic [7:0] ERASE_OK     = 8'h4F;
    localparam logic [7:0] ERASE_FAIL   = 8'h4C;
    localparam logic [3:0] NAK_BADCMD   = 4'h1;
    localparam logic [3:0] NAK_RXERR    = 4'h8;
    // Reply byte positions
    localparam logic [6:0] IDX_FIRST    = 7'h05;
    localparam logic [6:0] IDX_END_LO   = 7'h33;
    localparam logic [6:0] IDX_END_HI   = 7'h36;
    localparam logic [6:0] IDX_GROUP    = 7'h39;
    localparam logic [6:0] IDX_CHECK    = 7'h5D;
    localparam int         GROUP_BYTES  = 9;
    // Flash layout
    localparam logic [31:0] FLASH_END   = 32'h3F83_FFFF;
    localparam int          PAGE_WORDS  = 128;
    localparam logic [31:0] GRP_START [4] = '{32'h0000_0000, 32'h3F80_0000,
                                              32'h3F81_0000, 32'h3F82_0000};
    localparam logic [31:0] GRP_SIZE  [4] = '{32'h0000_2000, 32'h0000_4000,
                                              32'h0000_8000, 32'h0001_0000};
    localparam logic [7:0]  GRP_COUNT [4] = '{8'h00, 8'h02, 8'h01, 8'h03};
    // Received byte carrier
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } rx_byte_t;
    typedef enum logic [2:0] {
        ST_MODE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_CONF  = 3'b010,
        ST_ERASE = 3'b011,
        ST_INFO  = 3'b100,
        ST_DEAD  = 3'b101
    } state_t;
endpackage
`default_nettype wire

// file: hdl/group_table_rom.sv
// Purpose: Registered lookup of reply bytes 57 to 92, the flash block group table
// Assumes: Index is the 1-based reply byte number
// Notes:   Data appears one clock after the index
`default_nettype none
module group_table_rom
    import boot_resp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [6:0] byteIdx,
    output logic      [7:0] romData_ff
);
    wire  [6:0] relIdx  = byteIdx - IDX_GROUP;
    wire  [1:0] grpSel  = 2'(relIdx / 7'(GROUP_BYTES));
    wire  [3:0] grpByte = 4'(relIdx % 7'(GROUP_BYTES));
    logic [7:0] nxt_romData;

    // Start (4 bytes), size (4 bytes), count, each word LSB first
    always_comb begin
        nxt_romData = 8'h00;
        if (grpByte < 4'h4) begin
            nxt_romData = GRP_START[grpSel][8*grpByte[1:0] +: 8];
        end else if (grpByte < 4'h8) begin
            nxt_romData = GRP_SIZE[grpSel][8*grpByte[1:0] +: 8];
        end else begin
            nxt_romData = GRP_COUNT[grpSel];
        end
    end

    always_ff @(posedge ref_clk) begin
        romData_ff <= nxt_romData;
    end
endmodule
`default_nettype wire

// file: sim/flash_side_model.sv
// Purpose: Flash side of the responder: info page bytes and the erase engine
// Assumes: Erase request is a level held until the done pulse
// Notes:   Erase result comes from okSel, shown only with the done pulse
`default_nettype none
module flash_side_model
    import boot_resp_pkg::*;
#(
    parameter int ERASE_CYCLES = 40
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [6:0] headIdx,
    input  wire logic       eraseReq,
    input  wire logic       okSel,
    output logic      [7:0] headByte,
    output logic            eraseDone,
    output logic            eraseOk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] eraseCnt;
    logic [7:0] pat;
    // Info page bytes; outside 5..56 an inverted pattern shows
    assign pat      = {1'b0, headIdx} ^ 8'hA5;
    assign headByte = (headIdx >= 7'h05 && headIdx <= 7'h38) ? pat : ~pat;
    assign eraseOk  = eraseDone ? okSel : ~okSel;
    // Erase engine: one done pulse after a fixed time
    always_ff @(posedge ref_clk) begin
        if (reset || !eraseReq) begin
            eraseCnt  <= 8'h00;
            eraseDone <= 1'b0;
        end else begin
            eraseCnt  <= eraseCnt + 8'h01;
            eraseDone <= (eraseCnt == 8'(ERASE_CYCLES - 1));
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench of the serial boot command responder
// Assumes: Bench plays host and transmitter; flash side is a model
// Notes:   Expected reply bytes are queued and checked as they leave
`default_nettype none
module testbench
    import boot_resp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    rx_byte_t    rxByte = '0;
    logic        baudOk = 1'b1;
    logic        txReady = 1'b0;
    logic        okSel = 1'b0;
    logic [7:0]  headByte;
    logic        eraseDone, eraseOk, txValid_ff, eraseReq_ff, ioMode_ff;
    logic        aborted_ff, security_flag_ff;
    logic [7:0]  txData_ff;
    logic [6:0]  headIdx_ff;
    logic [31:0] lfsrState = 32'h3f8fa372;
    logic [7:0]  expQ[$];
    int          fail_count = 0;
    int          samples_checked = 0;

    boot_serial_command_responder u_boot_serial_command_responder (
        .ref_clk(ref_clk), .reset(reset), .rxByte(rxByte), .baudOk(baudOk),
        .txReady(txReady), .headByte(headByte), .eraseDone(eraseDone),
        .eraseOk(eraseOk), .txValid_ff(txValid_ff), .txData_ff(txData_ff),
        .headIdx_ff(headIdx_ff), .eraseReq_ff(eraseReq_ff), .ioMode_ff(ioMode_ff),
        .aborted_ff(aborted_ff), .security_flag_ff(security_flag_ff));
    flash_side_model u_flash_side_model (
        .ref_clk(ref_clk), .reset(reset), .headIdx(headIdx_ff),
        .eraseReq(eraseReq_ff), .okSel(okSel), .headByte(headByte),
        .eraseDone(eraseDone), .eraseOk(eraseOk));

    // Clock
    always #5 ref_clk = ~ref_clk;

    // Pseudo-random source of all random stimulus
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Transmitter readiness stalls at random
    always @(posedge ref_clk) begin
        #1;
        lfsrState = lfsr_next(lfsrState);
        txReady = lfsrState[0] | lfsrState[3];
    end

    function automatic logic [7:0] head_pat(input int idx);
        return 8'(idx) ^ 8'hA5;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Each byte leaving the block is compared with the oldest note
    always @(posedge ref_clk) begin
        if (reset === 1'b0 && txValid_ff === 1'b1 && txReady === 1'b1) begin
            if (expQ.size() == 0) begin
                fail_count++;
                $display("Error at %0t: unexpected byte %h", $time, txData_ff);
            end else begin
                check(txData_ff, expQ.pop_front());
            end
        end
    end

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while ((expQ.size() != 0 || txValid_ff !== 1'b0) && n < 3000);
        if (expQ.size() != 0 || txValid_ff !== 1'b0) begin
            fail_count++;
            $display("Error at %0t: reply never completed", $time);
            give_verdict();
        end
    endtask

    task automatic send(input logic [7:0] d, input logic err);
        wait_idle();
        rxByte = '{valid: 1'b1, err: err, data: d};
        @(posedge ref_clk);
        #1;
        rxByte = '{valid: 1'b0, err: lfsrState[20], data: lfsrState[15:8]};
        baudOk = lfsrState[9];
    endtask

    task automatic do_reset();
        reset = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        reset = 1'b0;
    endtask

    task automatic erase_run(input logic ok);
        okSel = ok;
        send(8'h40, 1'b0);
        expQ.push_back(8'h40);
        send(8'h54, 1'b0);
        expQ.push_back(8'h54);
        expQ.push_back(ok ? 8'h4F : 8'h4C);
        wait_idle();
        check({7'h00, security_flag_ff}, {7'h00, ok});
        check({7'h00, eraseReq_ff}, 8'h00);
    endtask

    task automatic info_run();
        logic [7:0]  body[$];
        logic [7:0]  sum;
        logic [31:0] st[4];
        logic [31:0] sz[4];
        logic [7:0]  ct[4];
        st = '{32'h0000_0000, 32'h3F80_0000, 32'h3F81_0000, 32'h3F82_0000};
        sz = '{32'h0000_2000, 32'h0000_4000, 32'h0000_8000, 32'h0001_0000};
        ct = '{8'h00, 8'h02, 8'h01, 8'h03};
        sum = 8'h00;
        for (int i = 5; i <= 56; i++)
            body.push_back((i >= 51 && i <= 54) ? 8'(32'h3F83_FFFF >> (8 * (i - 51))) : head_pat(i));
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 4; k++) body.push_back(8'(st[g] >> (8 * k)));
            for (int k = 0; k < 4; k++) body.push_back(8'(sz[g] >> (8 * k)));
            body.push_back(ct[g]);
        end
        send(8'h30, 1'b0);
        expQ.push_back(8'h30);
        foreach (body[j]) begin
            sum = sum + body[j];
            expQ.push_back(body[j]);
        end
        expQ.push_back(8'h00 - sum);
        wait_idle();
    endtask

    // Main sequence
    initial begin
        do_reset();
        check({1'b0, headIdx_ff}, 8'h05);
        send(8'h86, 1'b0);
        expQ.push_back(8'h86);
        send(8'h10, 1'b0);
        expQ.push_back(8'h01);
        send(8'h40, 1'b0);
        expQ.push_back(8'h40);
        send(8'h55, 1'b0);
        expQ.push_back(8'h41);
        send(8'h40, 1'b1);
        expQ.push_back(8'h48);
        send(8'h40, 1'b0);
        expQ.push_back(8'h40);
        send(8'h54, 1'b1);
        expQ.push_back(8'h48);
        erase_run(1'b0);
        erase_run(1'b1);
        info_run();
        send(8'h10, 1'b0);
        expQ.push_back(8'h31);
        // Clocked mode ignores the baud check and receive errors
        wait_idle();
        do_reset();
        baudOk = 1'b0;
        send(8'h30, 1'b0);
        expQ.push_back(8'h30);
        check({7'h00, ioMode_ff}, 8'h01);
        send(8'h40, 1'b1);
        expQ.push_back(8'h40);
        send(8'h77, 1'b0);
        expQ.push_back(8'h41);
        // UART with an unusable rate goes silent
        wait_idle();
        do_reset();
        baudOk = 1'b0;
        send(8'h86, 1'b0);
        send(8'h40, 1'b0);
        repeat (20) @(posedge ref_clk);
        #1;
        check({7'h00, aborted_ff}, 8'h01);
        check({7'h00, txValid_ff}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
